// *** shared/cmwo_pkg.sv ***
// constants for the card memory window offset register bank
// assumes 8-bit socket register space addressed by a 12-bit byte offset
package cmwo_pkg;

  localparam int unsigned NUM_WIN     = 5;
  localparam int unsigned REG_AW      = 12;
  localparam int unsigned REG_DW      = 8;
  localparam int unsigned OFF_W       = 14;
  localparam int unsigned WIN_IDX_W   = 3;

  // socket-space byte offsets, one entry per window
  localparam logic [11:0] OFF_LOW_ADDR [NUM_WIN] = '{
    12'h814, 12'h81C, 12'h824, 12'h82C, 12'h834
  };
  localparam logic [11:0] OFF_HIGH_ADDR [NUM_WIN] = '{
    12'h815, 12'h81D, 12'h825, 12'h82D, 12'h835
  };

  // high-byte field layout
  localparam int unsigned WP_BIT      = 7;
  localparam int unsigned ATTR_BIT    = 6;
  localparam int unsigned OFF_HI_MSB  = 5;
  localparam int unsigned OFF_HI_W    = 6;

  localparam logic [7:0]  REG_RESET   = 8'h00;
  localparam logic [7:0]  UNMAPPED_RD = 8'h00;

  typedef logic [REG_DW-1:0] cmwo_byte_type;
  typedef logic [OFF_W-1:0]  cmwo_addr_type;

endpackage

// *** core/cmwo_xlate.sv ***
// offset adder for one memory window
// assumes host page and offset are both A25..A12 page numbers
`timescale 1ns/1ps
`default_nettype none
module cmwo_xlate #(
  parameter int unsigned WIDTH = 14
) (
  input  wire logic [WIDTH-1:0] host_page_in,
  input  wire logic [WIDTH-1:0] offset_in,
  output logic      [WIDTH-1:0] card_page_out
);

  // wraps modulo the card address space, carry out is dropped on purpose
  always_comb begin
    card_page_out = WIDTH'(host_page_in + offset_in);
  end

endmodule
`default_nettype wire

// *** core/cmwo_regs.sv ***
// offset-address register bank for five card memory windows
// assumes a byte-wide socket register port and an outside window-hit decode
//
// How it works
// - the low-byte register supplies offset bits A19 to A12
// - high-byte bits 5..0 supply offset bits A25 to A20
// - high-byte bit 7 set blocks writes through the window
// - high-byte bit 6 selects attribute memory, clear selects common memory
// - five windows, each with low and high read/write registers, reset zero
`timescale 1ns/1ps
`default_nettype none
module cmwo_regs
  import cmwo_pkg::*;
#(
  parameter int unsigned N_WIN = NUM_WIN
) (
  input  wire logic                  core_clk_in,
  input  wire logic                  rst_n_in,
  // socket register port
  input  wire logic [REG_AW-1:0]     reg_addr_in,
  input  wire logic                  reg_wr_in,
  input  wire logic                  reg_rd_in,
  input  wire logic [REG_DW-1:0]     reg_wdata_in,
  output logic      [REG_DW-1:0]     reg_rdata_out,
  output logic                       reg_rvalid_out,
  // host memory access that hit a window
  input  wire logic                  acc_valid_in,
  input  wire logic [WIN_IDX_W-1:0]  acc_win_in,
  input  wire logic                  acc_write_in,
  input  wire logic [OFF_W-1:0]      acc_host_page_in,
  // translated access toward the card
  output logic                       card_valid_out,
  output logic [OFF_W-1:0]           card_page_out,
  output logic                       card_attr_out,
  output logic                       card_write_out,
  output logic                       wr_blocked_out,
  // per-window configuration view
  output logic [N_WIN-1:0]           window_write_protect_out,
  output logic [N_WIN-1:0]           win_attr_out
);

  cmwo_byte_type low_q  [N_WIN];
  cmwo_byte_type low_d  [N_WIN];
  cmwo_byte_type high_q [N_WIN];
  cmwo_byte_type high_d [N_WIN];
  cmwo_addr_type xlat   [N_WIN];

  logic [N_WIN-1:0] hit_low;
  logic [N_WIN-1:0] hit_high;

  cmwo_byte_type rdata_q;
  cmwo_byte_type rdata_d;
  logic          rvalid_q;
  logic          rvalid_d;

  logic          cvalid_q;
  logic          cvalid_d;
  cmwo_addr_type cpage_q;
  cmwo_addr_type cpage_d;
  logic          cattr_q;
  logic          cattr_d;
  logic          cwrite_q;
  logic          cwrite_d;
  logic          blk_q;
  logic          blk_d;

  cmwo_byte_type sel_low;
  cmwo_byte_type sel_high;
  cmwo_addr_type sel_xlat;
  logic          win_ok;
  logic          regs_nonzero;

  genvar g;
  generate
    for (g = 0; g < N_WIN; g++) begin : g_win
      assign hit_low[g]  = (reg_addr_in == OFF_LOW_ADDR[g]);
      assign hit_high[g] = (reg_addr_in == OFF_HIGH_ADDR[g]);
      assign window_write_protect_out[g] = high_q[g][WP_BIT];
      assign win_attr_out[g]             = high_q[g][ATTR_BIT];

      cmwo_xlate #(
        .WIDTH (OFF_W)
      ) u_xlate (
        .host_page_in  (acc_host_page_in),
        .offset_in     ({high_q[g][OFF_HI_MSB:0], low_q[g]}),
        .card_page_out (xlat[g])
      );
    end
  endgenerate

  // register file: write and read decode
  always_comb begin
    rdata_d  = rdata_q;
    rvalid_d = reg_rd_in;
    for (int i = 0; i < N_WIN; i++) begin
      low_d[i]  = low_q[i];
      high_d[i] = high_q[i];
      if (reg_wr_in && hit_low[i]) begin
        low_d[i] = reg_wdata_in;
      end
      if (reg_wr_in && hit_high[i]) begin
        high_d[i] = reg_wdata_in;
      end
    end
    if (reg_rd_in) begin
      rdata_d = UNMAPPED_RD;
      for (int i = 0; i < N_WIN; i++) begin
        if (hit_low[i]) begin
          rdata_d = low_q[i];
        end
        if (hit_high[i]) begin
          rdata_d = high_q[i];
        end
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < N_WIN; i++) begin
        low_q[i]  <= REG_RESET;
        high_q[i] <= REG_RESET;
      end
      rdata_q  <= REG_RESET;
      rvalid_q <= 1'b0;
    end else begin
      for (int i = 0; i < N_WIN; i++) begin
        low_q[i]  <= low_d[i];
        high_q[i] <= high_d[i];
      end
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign reg_rdata_out  = rdata_q;
  assign reg_rvalid_out = rvalid_q;

  // window select; an index past the last window selects nothing
  always_comb begin
    win_ok   = 1'b0;
    sel_low  = REG_RESET;
    sel_high = REG_RESET;
    sel_xlat = '0;
    for (int i = 0; i < N_WIN; i++) begin
      if (acc_win_in == WIN_IDX_W'(i)) begin
        win_ok   = 1'b1;
        sel_low  = low_q[i];
        sel_high = high_q[i];
        sel_xlat = xlat[i];
      end
    end
  end

  // access path, one cycle of latency; a write landing together with a
  // register update sees the old settings
  always_comb begin
    cvalid_d = 1'b0;
    blk_d    = 1'b0;
    cpage_d  = cpage_q;
    cattr_d  = cattr_q;
    cwrite_d = cwrite_q;
    if (acc_valid_in && win_ok) begin
      if (acc_write_in && sel_high[WP_BIT]) begin
        blk_d = 1'b1;
      end else begin
        cvalid_d = 1'b1;
        cpage_d  = sel_xlat;
        cattr_d  = sel_high[ATTR_BIT];
        cwrite_d = acc_write_in;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cvalid_q <= 1'b0;
      blk_q    <= 1'b0;
      cpage_q  <= '0;
      cattr_q  <= 1'b0;
      cwrite_q <= 1'b0;
    end else begin
      cvalid_q <= cvalid_d;
      blk_q    <= blk_d;
      cpage_q  <= cpage_d;
      cattr_q  <= cattr_d;
      cwrite_q <= cwrite_d;
    end
  end

  assign card_valid_out = cvalid_q;
  assign card_page_out  = cpage_q;
  assign card_attr_out  = cattr_q;
  assign card_write_out = cwrite_q;
  assign wr_blocked_out = blk_q;

  // checks
  // any of the ten registers off its reset value
  always_comb begin
    regs_nonzero = 1'b0;
    for (int i = 0; i < N_WIN; i++) begin
      regs_nonzero = regs_nonzero | (low_q[i] != REG_RESET) | (high_q[i] != REG_RESET);
    end
  end

  sequence s_wr_low0;
    reg_wr_in && hit_low[0];
  endsequence

  sequence s_rd_low0;
    reg_rd_in && !reg_wr_in && hit_low[0];
  endsequence

  property p_low_bits;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      acc_valid_in && win_ok && !(acc_write_in && sel_high[WP_BIT])
        && acc_host_page_in == '0
      |=> card_valid_out && card_page_out[7:0] == $past(sel_low);
  endproperty
  a_low_bits: assert property (p_low_bits)
    else $error("offset low byte not mapped to A19..A12");

  property p_high_bits;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      acc_valid_in && win_ok && !(acc_write_in && sel_high[WP_BIT])
        && acc_host_page_in == '0
      |=> card_page_out[OFF_W-1:8] == $past(sel_high[OFF_HI_MSB:0]);
  endproperty
  a_high_bits: assert property (p_high_bits)
    else $error("offset high bits not mapped to A25..A20");

  property p_wp_block;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      acc_valid_in && win_ok && acc_write_in && sel_high[WP_BIT]
      |=> wr_blocked_out && !card_valid_out;
  endproperty
  a_wp_block: assert property (p_wp_block)
    else $error("write through protected window not blocked");

  property p_wp_allow;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      acc_valid_in && win_ok && !sel_high[WP_BIT]
      |=> card_valid_out && !wr_blocked_out && card_write_out == $past(acc_write_in);
  endproperty
  a_wp_allow: assert property (p_wp_allow)
    else $error("access through open window not passed");

  property p_attr_sel;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      card_valid_out |-> card_attr_out == $past(sel_high[ATTR_BIT]);
  endproperty
  a_attr_sel: assert property (p_attr_sel)
    else $error("memory space select does not follow bit 6");

  property p_reg_rw;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      s_wr_low0 ##1 s_rd_low0 |=> reg_rvalid_out && reg_rdata_out == $past(reg_wdata_in, 2);
  endproperty
  a_reg_rw: assert property (p_reg_rw)
    else $error("window register did not read back written value");

  property p_reset_zero;
    @(posedge core_clk_in)
      $rose(rst_n_in) |-> !regs_nonzero;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("window register not zero after reset");

  property p_sum;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      card_valid_out |-> card_page_out ==
        OFF_W'($past(acc_host_page_in) + $past({sel_high[OFF_HI_MSB:0], sel_low}));
  endproperty
  a_sum: assert property (p_sum)
    else $error("card page is not host page plus offset");

endmodule
`default_nettype wire

// *** tb/cmwo_card_model.sv ***
// card side: logs each translated access that reaches the card
// assumes one access per card valid pulse, page is A25..A12
`timescale 1ns/1ps
`default_nettype none
module cmwo_card_model
  import cmwo_pkg::*;
(
  input  wire logic             core_clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             valid_in,
  input  wire logic [OFF_W-1:0] page_in,
  input  wire logic             attr_in,
  input  wire logic             write_in,
  output var  int               acc_cnt_out,
  output var  logic [15:0]      last_out
);
  // attr and direction logged with the page so a wrong space shows up
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acc_cnt_out <= 0;
      last_out    <= 16'h0000;
    end else if (valid_in) begin
      acc_cnt_out <= acc_cnt_out + 1;
      last_out    <= {attr_in, write_in, page_in};
    end
  end
endmodule
`default_nettype wire

// *** tb/tb_card_mem_window_offset_regs.sv ***
// self-checking bench for the window offset register bank
// assumes answers come one cycle after each strobe
`timescale 1ns/1ps
`default_nettype none
module tb_card_mem_window_offset_regs
  import cmwo_pkg::*;
;
  typedef struct packed {
    logic [7:0]  lo;
    logic [7:0]  hi;
    logic [13:0] host;
    logic        wr;
    logic        blk;
    logic [13:0] page;
  } cmwo_row_type;
  // row 1 wraps past the top, row 2 is refused and keeps the old page
  localparam cmwo_row_type ROWS [5] = '{
    '{8'h02, 8'h41, 14'h0001, 1'h0, 1'h0, 14'h0103},
    '{8'hFF, 8'h3F, 14'h0001, 1'h0, 1'h0, 14'h0000},
    '{8'h80, 8'h80, 14'h0010, 1'h1, 1'h1, 14'h0000},
    '{8'h34, 8'h12, 14'h1000, 1'h1, 1'h0, 14'h2234},
    '{8'h01, 8'hC0, 14'h0005, 1'h0, 1'h0, 14'h0006}};
  logic        core_clk = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  logic        acc_valid = 1'h0, acc_write = 1'h0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0]  reg_wdata = 8'h00, rdata;
  logic [2:0]  acc_win = 3'h0;
  logic [13:0] host = 14'h0000, card_page;
  logic        rvalid, card_valid, card_attr, card_write, wr_blocked;
  logic [4:0]  wp, attr;
  logic [15:0] last;
  int          acc_cnt, miscompares = 0, comparisons = 0, cycles = 0, exp_cnt = 0;

  cmwo_regs cmwo_regs_inst (.core_clk_in(core_clk), .rst_n_in(rst_n),
    .reg_addr_in(reg_addr), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_wdata_in(reg_wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .acc_valid_in(acc_valid), .acc_win_in(acc_win), .acc_write_in(acc_write),
    .acc_host_page_in(host), .card_valid_out(card_valid), .card_page_out(card_page),
    .card_attr_out(card_attr), .card_write_out(card_write), .wr_blocked_out(wr_blocked),
    .window_write_protect_out(wp), .win_attr_out(attr));
  cmwo_card_model cmwo_card_model_inst (.core_clk_in(core_clk), .rst_n_in(rst_n),
    .valid_in(card_valid), .page_in(card_page), .attr_in(card_attr),
    .write_in(card_write), .acc_cnt_out(acc_cnt), .last_out(last));

  always #2 core_clk = ~core_clk;

  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // whole run is about 120 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic reg_wr_t(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask

  task automatic reg_rd_chk(input logic [11:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1;
    chk("rvalid", 16'h0001, {15'h0000, rvalid});
    chk("rdata", {8'h00, exp}, {8'h00, rdata});
  endtask

  task automatic acc(input logic [2:0] w, input logic wr, input logic [13:0] h);
    @(posedge core_clk);
    acc_win <= w;
    acc_write <= wr;
    host <= h;
    acc_valid <= 1'h1;
    @(posedge core_clk);
    acc_valid <= 1'h0;
    #1;
  endtask

  task automatic zero_chk();
    for (int i = 0; i < NUM_WIN; i++) begin
      reg_rd_chk(OFF_LOW_ADDR[i], 8'h00);
      reg_rd_chk(OFF_HIGH_ADDR[i], 8'h00);
    end
    chk("wp", 16'h0000, {11'h000, wp});
    chk("attr", 16'h0000, {11'h000, attr});
  endtask

  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'h1;
    zero_chk();
    foreach (ROWS[i]) begin
      reg_wr_t(OFF_LOW_ADDR[i], ROWS[i].lo);
      reg_wr_t(OFF_HIGH_ADDR[i], ROWS[i].hi);
      reg_rd_chk(OFF_LOW_ADDR[i], ROWS[i].lo);
      reg_rd_chk(OFF_HIGH_ADDR[i], ROWS[i].hi);
      chk("wp_bit", {15'h0000, ROWS[i].hi[7]}, {15'h0000, wp[i]});
      chk("attr_bit", {15'h0000, ROWS[i].hi[6]}, {15'h0000, attr[i]});
      acc(i[2:0], ROWS[i].wr, ROWS[i].host);
      chk("blocked", {15'h0000, ROWS[i].blk}, {15'h0000, wr_blocked});
      chk("card_valid", {15'h0000, !ROWS[i].blk}, {15'h0000, card_valid});
      chk("card_page", {2'h0, ROWS[i].page}, {2'h0, card_page});
      if (!ROWS[i].blk) begin
        exp_cnt++;
      end
      @(posedge core_clk);
      #1;
      if (!ROWS[i].blk) begin
        chk("card_log", {ROWS[i].hi[6], ROWS[i].wr, ROWS[i].page}, last);
      end
      chk("card_count", exp_cnt[15:0], acc_cnt[15:0]);
    end
    // zero host page shows the bare offset on the card side
    acc(3'h3, 1'h0, 14'h0000);
    chk("bare_offset", {2'h0, ROWS[3].hi[5:0], ROWS[3].lo}, {2'h0, card_page});
    chk("bare_attr", {15'h0000, ROWS[3].hi[6]}, {15'h0000, card_attr});
    // window index beyond the bank must stay silent
    acc(3'h5, 1'h0, 14'h0001);
    chk("no_win_valid", 16'h0000, {15'h0000, card_valid});
    chk("no_win_blocked", 16'h0000, {15'h0000, wr_blocked});
    // write then read back to back, then write and read in one cycle
    @(posedge core_clk);
    reg_addr <= OFF_LOW_ADDR[0];
    reg_wdata <= 8'h5A;
    reg_wr <= 1'h1;
    @(posedge core_clk);
    reg_wr <= 1'h0;
    reg_rd <= 1'h1;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1;
    chk("b2b_rvalid", 16'h0001, {15'h0000, rvalid});
    chk("b2b_rdata", 16'h005A, {8'h00, rdata});
    @(posedge core_clk);
    reg_wdata <= 8'hA5;
    reg_wr <= 1'h1;
    reg_rd <= 1'h1;
    @(posedge core_clk);
    reg_wr <= 1'h0;
    reg_rd <= 1'h0;
    #1;
    chk("same_rvalid", 16'h0001, {15'h0000, rvalid});
    chk("same_rdata_old", 16'h005A, {8'h00, rdata});
    reg_rd_chk(OFF_LOW_ADDR[0], 8'hA5);
    reg_wr_t(12'h816, 8'hFF);
    reg_rd_chk(12'h816, 8'h00);
    reg_rd_chk(OFF_HIGH_ADDR[0], ROWS[0].hi);
    @(posedge core_clk);
    rst_n <= 1'h0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'h1;
    zero_chk();
    stop_test();
  end
endmodule
`default_nettype wire
